/* regulator_fault_power_good.sv */
`timescale 1ns/1ps
`default_nettype none
module regulator_fault_power_good #(
  parameter bit VARIANT_3V3 = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // supervisory levels
  input wire logic en_ok,
  input wire logic bias_ok,
  input wire logic init_done,
  // power stage sensing
  input wire logic [7:0] output_sense_input,
  input wire logic [7:0] ls_current,
  input wire logic [7:0] die_temp,
  input wire logic [7:0] ctl_on_cycles,
  // power stage drive
  output logic hs_gate,
  output logic ls_gate,
  output logic [11:0] ss_ref_mv,
  // open-drain power-good pin
  output logic output_good_flag_o,
  output logic output_good_flag_oe
);

  localparam logic [7:0] PERIOD_CYC =
    VARIANT_3V3 ? 8'(fault_pkg::PERIOD_3V3_CYC) : 8'(fault_pkg::PERIOD_2V5_CYC);
  localparam logic [11:0] TARGET_MV =
    VARIANT_3V3 ? 12'(fault_pkg::TARGET_3V3_MV) : 12'(fault_pkg::TARGET_2V5_MV);
  localparam logic [7:0] MIN_ON = 8'(fault_pkg::MIN_ON_CYC);
  localparam logic [7:0] MAX_ON = PERIOD_CYC - 8'(fault_pkg::MIN_OFF_CYC);

  // registers
  logic [7:0] pg_mode_r;
  logic [1:0] ov_level_sel_r;
  logic [1:0] pg_level_sel_r;
  logic [1:0] ot_level_sel_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pg_mode_r <= fault_pkg::PG_MODE_RST;
      ov_level_sel_r <= fault_pkg::OV_LEVEL_RST;
      pg_level_sel_r <= fault_pkg::PG_LEVEL_RST;
      ot_level_sel_r <= fault_pkg::OT_LEVEL_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        fault_pkg::ADDR_PG_MODE: pg_mode_r <= reg_wdata & fault_pkg::PG_MODE_MASK;
        fault_pkg::ADDR_OV_LEVEL: ov_level_sel_r <= reg_wdata[1:0];
        fault_pkg::ADDR_PG_LEVEL: pg_level_sel_r <= reg_wdata[1:0];
        fault_pkg::ADDR_OT_LEVEL: ot_level_sel_r <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  fault_pkg::state_t state_r;
  fault_pkg::state_t state_nxt;
  logic good_r;
  logic startup_done_r;
  logic first_pulse_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        fault_pkg::ADDR_PG_MODE: reg_rdata <= pg_mode_r;
        fault_pkg::ADDR_OV_LEVEL: reg_rdata <= {6'h00, ov_level_sel_r};
        fault_pkg::ADDR_PG_LEVEL: reg_rdata <= {6'h00, pg_level_sel_r};
        fault_pkg::ADDR_OT_LEVEL: reg_rdata <= {6'h00, ot_level_sel_r};
        fault_pkg::ADDR_STATUS:
          reg_rdata <= {2'h0, first_pulse_r, startup_done_r, good_r, state_r};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // threshold selection
  logic [7:0] ov_pct;
  logic [7:0] pg_pct;
  logic [7:0] ot_limit;
  assign ov_pct = fault_pkg::OV_BASE_PCT +
                  fault_pkg::LEVEL_STEP_PCT * {6'h00, ov_level_sel_r};
  assign pg_pct = fault_pkg::PG_BASE_PCT +
                  fault_pkg::LEVEL_STEP_PCT * {6'h00, pg_level_sel_r};
  assign ot_limit = fault_pkg::thermal_limit(ot_level_sel_r);

  // comparator outputs, then synchronised
  logic [7:0] cmp_raw;
  logic [7:0] cmp_s;
  assign cmp_raw[0] = output_sense_input > ov_pct;
  assign cmp_raw[1] = output_sense_input < (ov_pct - fault_pkg::OV_HYST_PCT);
  assign cmp_raw[2] = ls_gate && (ls_current > fault_pkg::OC_TRIP_DECI_A);
  assign cmp_raw[3] = ls_current == 8'h00;
  assign cmp_raw[4] = die_temp > ot_limit;
  assign cmp_raw[5] = die_temp <= (ot_limit - fault_pkg::OT_HYST_C);
  assign cmp_raw[6] = output_sense_input > pg_pct;
  assign cmp_raw[7] = output_sense_input < (pg_pct - fault_pkg::PG_HYST_PCT);

  bit_sync #(.WIDTH(8)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .async_in(cmp_raw),
    .sync_out(cmp_s)
  );

  logic ov_fault;
  ov_filter u_ov_filter (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ov_level(cmp_s[0]),
    .ov_fault(ov_fault)
  );

  logic oc_fault;
  logic ls_zero;
  logic ot_fault;
  logic ot_clear;
  logic ov_clear;
  assign ov_clear = cmp_s[1];
  assign oc_fault = cmp_s[2];
  assign ls_zero = cmp_s[3];
  assign ot_fault = cmp_s[4];
  assign ot_clear = cmp_s[5];

  logic enabled;
  assign enabled = en_ok && bias_ok && init_done;

  // soft-start reference compared with the sensed output, both as fractions of target
  logic [23:0] ss_scaled;
  logic [23:0] sense_scaled;
  logic [23:0] band_scaled;
  logic ss_above_sense;
  logic ss_in_band;
  assign ss_scaled = 24'(ss_ref_mv) * 24'd100;
  assign sense_scaled = 24'(output_sense_input) * 24'(TARGET_MV);
  assign band_scaled = 24'(TARGET_MV) * 24'(fault_pkg::PG_BAND_LOW_PCT);
  assign ss_above_sense = ss_scaled > sense_scaled;
  assign ss_in_band = ss_scaled >= band_scaled;

  // hiccup blanking
  logic [11:0] hic_cnt_r;
  logic hic_done;
  assign hic_done = hic_cnt_r >= 12'(fault_pkg::HICCUP_CYC);

  always_comb begin
    state_nxt = state_r;
    if (!enabled) begin
      state_nxt = fault_pkg::ST_OFF;
    end else begin
      case (state_r)
        fault_pkg::ST_OFF: state_nxt = fault_pkg::ST_START;
        fault_pkg::ST_START, fault_pkg::ST_RUN: begin
          if (ov_fault) begin
            state_nxt = fault_pkg::ST_OV_LATCH;
          end else if (oc_fault) begin
            state_nxt = fault_pkg::ST_OC_DRAIN;
          end else if (ot_fault) begin
            state_nxt = fault_pkg::ST_THERMAL;
          end else if (state_r == fault_pkg::ST_START && ss_above_sense) begin
            state_nxt = fault_pkg::ST_RUN;
          end
        end
        fault_pkg::ST_OC_DRAIN: begin
          if (ls_zero) begin
            state_nxt = fault_pkg::ST_HICCUP;
          end
        end
        fault_pkg::ST_HICCUP: begin
          if (hic_done) begin
            state_nxt = fault_pkg::ST_START;
          end
        end
        fault_pkg::ST_OV_LATCH: state_nxt = fault_pkg::ST_OV_LATCH;
        fault_pkg::ST_THERMAL: begin
          if (ot_clear) begin
            state_nxt = fault_pkg::ST_START;
          end
        end
        default: state_nxt = fault_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= fault_pkg::ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hic_cnt_r <= 12'h000;
    end else if (state_r == fault_pkg::ST_HICCUP && !hic_done) begin
      hic_cnt_r <= hic_cnt_r + 12'h001;
    end else if (state_r != fault_pkg::ST_HICCUP) begin
      hic_cnt_r <= 12'h000;
    end
  end

  // soft-start ramp, one step per microsecond
  logic [6:0] us_cnt_r;
  logic us_tick;
  logic ramping;
  logic ss_reset;
  logic [11:0] ss_step;
  logic [12:0] ss_sum;
  assign us_tick = us_cnt_r == 7'(fault_pkg::US_CYC - 1);
  assign ramping = state_r == fault_pkg::ST_START || state_r == fault_pkg::ST_RUN;
  assign ss_reset = state_r == fault_pkg::ST_OFF || state_r == fault_pkg::ST_OC_DRAIN ||
                    state_r == fault_pkg::ST_HICCUP || state_r == fault_pkg::ST_THERMAL;
  assign ss_step = pg_mode_r[fault_pkg::RATE_BIT] ?
                   fault_pkg::SS_STEP_FAST_MV : fault_pkg::SS_STEP_SLOW_MV;
  assign ss_sum = {1'b0, ss_ref_mv} + {1'b0, ss_step};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      us_cnt_r <= 7'h00;
    end else if (us_tick || !ramping) begin
      us_cnt_r <= 7'h00;
    end else begin
      us_cnt_r <= us_cnt_r + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ss_ref_mv <= 12'h000;
      startup_done_r <= 1'b0;
    end else if (ss_reset || state_nxt == fault_pkg::ST_OC_DRAIN) begin
      ss_ref_mv <= 12'h000;
      startup_done_r <= 1'b0;
    end else if (ramping && us_tick && !startup_done_r) begin
      if (ss_sum >= {1'b0, TARGET_MV}) begin
        ss_ref_mv <= TARGET_MV;
        startup_done_r <= 1'b1;
      end else begin
        ss_ref_mv <= ss_sum[11:0];
      end
    end
  end

  // pwm: high-side first, low-side for the rest of the period
  logic [7:0] pwm_cnt_r;
  logic [7:0] on_len;
  logic pwm_hs;
  always_comb begin
    if (output_sense_input < fault_pkg::STARTUP_SMALL_PCT || ctl_on_cycles < MIN_ON) begin
      on_len = MIN_ON;
    end else if (ctl_on_cycles > MAX_ON) begin
      on_len = MAX_ON;
    end else begin
      on_len = ctl_on_cycles;
    end
  end
  assign pwm_hs = pwm_cnt_r < on_len;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_cnt_r <= 8'h00;
    end else if (state_r != fault_pkg::ST_RUN || pwm_cnt_r == PERIOD_CYC - 8'h01) begin
      pwm_cnt_r <= 8'h00;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 8'h01;
    end
  end

  // discharge phase of the over-voltage latch
  logic ov_discharge_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ov_discharge_r <= 1'b0;
    end else if (state_r != fault_pkg::ST_OV_LATCH && state_nxt == fault_pkg::ST_OV_LATCH) begin
      ov_discharge_r <= 1'b1;
    end else if (state_r != fault_pkg::ST_OV_LATCH || ov_clear) begin
      ov_discharge_r <= 1'b0;
    end
  end

  logic run_next;
  assign run_next = state_r == fault_pkg::ST_RUN && state_nxt == fault_pkg::ST_RUN;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hs_gate <= 1'b0;
      ls_gate <= 1'b0;
    end else begin
      hs_gate <= run_next && pwm_hs;
      ls_gate <= (run_next && !pwm_hs) || state_nxt == fault_pkg::ST_OC_DRAIN ||
                 (state_nxt == fault_pkg::ST_OV_LATCH &&
                  (state_r != fault_pkg::ST_OV_LATCH || (ov_discharge_r && !ov_clear)));
    end
  end

  // power-good
  logic pg_hyst_r;
  logic good_nxt;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pg_hyst_r <= 1'b0;
    end else if (cmp_s[6]) begin
      pg_hyst_r <= 1'b1;
    end else if (cmp_s[7]) begin
      pg_hyst_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      first_pulse_r <= 1'b0;
    end else if (!ramping) begin
      first_pulse_r <= 1'b0;
    end else if (hs_gate) begin
      first_pulse_r <= 1'b1;
    end
  end

  always_comb begin
    good_nxt = 1'b0;
    if (enabled && run_next && first_pulse_r) begin
      if (pg_mode_r[fault_pkg::MODE_BIT] || startup_done_r) begin
        good_nxt = pg_hyst_r;
      end else begin
        good_nxt = ss_in_band;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      good_r <= 1'b0;
    end else begin
      good_r <= good_nxt;
    end
  end

  // open drain: pulled low whenever the output is not good
  assign output_good_flag_o = 1'b0;
  assign output_good_flag_oe = !good_r;

endmodule // regulator_fault_power_good
`default_nettype wire

/* fault_pkg.sv */
package fault_pkg;

  // clock and time base
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int US_CYC = CLK_MHZ;

  // factory variants: switching frequency and target output
  localparam int FSW_2V5_HZ = 1_300_000;
  localparam int FSW_3V3_HZ = 1_500_000;
  localparam int PERIOD_2V5_CYC = CLK_HZ / FSW_2V5_HZ;
  localparam int PERIOD_3V3_CYC = CLK_HZ / FSW_3V3_HZ;
  localparam int TARGET_2V5_MV = 2500;
  localparam int TARGET_3V3_MV = 3300;

  // minimum switch intervals, least times round up
  localparam int MIN_ON_NS = 50;
  localparam int MIN_OFF_NS = 100;
  localparam int MIN_ON_CYC = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
  localparam int MIN_OFF_CYC = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;

  // protection timing
  localparam int OV_DELAY_US = 5;
  localparam int OV_DELAY_CYC = OV_DELAY_US * CLK_MHZ;
  localparam int HICCUP_US = 20;
  localparam int HICCUP_CYC = HICCUP_US * CLK_MHZ;

  // trip levels; current in 100 mA steps, voltage in percent of target
  localparam logic [7:0] OC_TRIP_DECI_A = 8'h3C;
  localparam logic [7:0] OV_BASE_PCT = 8'h69;
  localparam logic [7:0] PG_BASE_PCT = 8'h50;
  localparam logic [7:0] LEVEL_STEP_PCT = 8'h05;
  localparam logic [7:0] OV_HYST_PCT = 8'h05;
  localparam logic [7:0] PG_HYST_PCT = 8'h05;
  localparam logic [7:0] OT_HYST_C = 8'h14;
  localparam logic [7:0] STARTUP_SMALL_PCT = 8'h0A;
  localparam int PG_BAND_LOW_PCT = 98;
  localparam logic [11:0] SS_STEP_SLOW_MV = 12'h001;
  localparam logic [11:0] SS_STEP_FAST_MV = 12'h002;

  // register map
  localparam logic [7:0] ADDR_PG_MODE = 8'h14;
  localparam logic [7:0] ADDR_OV_LEVEL = 8'h17;
  localparam logic [7:0] ADDR_PG_LEVEL = 8'h18;
  localparam logic [7:0] ADDR_OT_LEVEL = 8'h19;
  localparam logic [7:0] ADDR_STATUS = 8'h1E;
  localparam int MODE_BIT = 0;
  localparam int SOFTSTOP_BIT = 2;
  localparam int RATE_BIT = 3;
  localparam logic [7:0] PG_MODE_MASK = 8'h0D;
  localparam logic [7:0] PG_MODE_RST = 8'h01;
  localparam logic [1:0] OV_LEVEL_RST = 2'h3;
  localparam logic [1:0] PG_LEVEL_RST = 2'h2;
  localparam logic [1:0] OT_LEVEL_RST = 2'h3;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_START = 3'b001,
    ST_RUN = 3'b010,
    ST_OC_DRAIN = 3'b011,
    ST_HICCUP = 3'b100,
    ST_OV_LATCH = 3'b101,
    ST_THERMAL = 3'b110
  } state_t;

  function automatic logic [7:0] thermal_limit(input logic [1:0] code);
    case (code)
      2'h0: thermal_limit = 8'h4B;
      2'h1: thermal_limit = 8'h55;
      2'h2: thermal_limit = 8'h7D;
      default: thermal_limit = 8'h91;
    endcase
  endfunction

endpackage

/* bit_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser, one stage pair per bit
module bit_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic hold_r;
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          meta_r <= 1'b0;
          hold_r <= 1'b0;
        end else begin
          meta_r <= async_in[i];
          hold_r <= meta_r;
        end
      end
      assign sync_out[i] = hold_r;
    end
  endgenerate

endmodule // bit_sync
`default_nettype wire

/* ov_filter.sv */
`timescale 1ns/1ps
`default_nettype none
// qualifies the over-voltage comparator: it must stay high for the whole delay
module ov_filter (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // comparator level, already synchronised
  input wire logic ov_level,
  output logic ov_fault
);

  logic [9:0] cnt_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 10'h000;
      ov_fault <= 1'b0;
    end else if (!ov_level) begin
      cnt_r <= 10'h000;
      ov_fault <= 1'b0;
    end else if (cnt_r >= 10'(fault_pkg::OV_DELAY_CYC)) begin
      ov_fault <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 10'h001;
    end
  end

endmodule // ov_filter
`default_nettype wire

/* fault_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module fault_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // supervisory levels
  input wire logic en_ok,
  input wire logic bias_ok,
  input wire logic init_done,
  // power stage
  input wire logic [7:0] output_sense_input,
  input wire logic [7:0] ls_current,
  input wire logic [7:0] die_temp,
  input wire logic [7:0] ctl_on_cycles,
  input wire logic hs_gate,
  input wire logic ls_gate,
  input wire logic [11:0] ss_ref_mv,
  // power-good pin
  input wire logic output_good_flag_o,
  input wire logic output_good_flag_oe
);
  logic [1:0] ov_r, pg_r, ot_r;
  logic [9:0] ov_cnt_r;
  logic [3:0] small_r;
  logic ovl_r, on_w, seen_r;
  logic [7:0] ov_pct, ov_lo, pg_lo, ot_lim;
  assign on_w = en_ok && bias_ok && init_done;
  assign ov_pct = 8'h69 + {6'h00, ov_r} * 8'h05;
  assign ov_lo = ov_pct - 8'h05;
  assign pg_lo = 8'h4B + {6'h00, pg_r} * 8'h05;
  always_comb begin
    case (ot_r)
      2'h0: ot_lim = 8'h4B;
      2'h1: ot_lim = 8'h55;
      2'h2: ot_lim = 8'h7D;
      default: ot_lim = 8'h91;
    endcase
  end
  // shadow of the level fields
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ov_r <= 2'h3;
      pg_r <= 2'h2;
      ot_r <= 2'h3;
    end else if (reg_wr) begin
      if (reg_addr == 8'h17) ov_r <= reg_wdata[1:0];
      if (reg_addr == 8'h18) pg_r <= reg_wdata[1:0];
      if (reg_addr == 8'h19) ot_r <= reg_wdata[1:0];
    end
  end
  // length of the present excursion above the trip and the latch it must cause
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ov_cnt_r <= 10'h000;
      ovl_r <= 1'b0;
      small_r <= 4'h0;
      seen_r <= 1'b0;
    end else begin
      small_r <= {small_r[2:0], output_sense_input < 8'h0A};
      if (!on_w) seen_r <= 1'b0;
      else if (hs_gate) seen_r <= 1'b1;
      if (!on_w || output_sense_input <= ov_pct) ov_cnt_r <= 10'h000;
      else if (ov_cnt_r != 10'h3FF) ov_cnt_r <= ov_cnt_r + 10'h001;
      if (!on_w) ovl_r <= 1'b0;
      else if (ov_cnt_r == 10'h208) ovl_r <= 1'b1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  oc_response_a:
    assert property ((ls_gate && ls_current > 8'h3C) [*3] |-> ##[0:3]
      (output_good_flag_oe && ss_ref_mv == 12'h000 && !hs_gate && ls_gate))
    else $error("over-current response missing");
  ov_trip_a:
    assert property (ov_cnt_r == 10'h208 |-> !hs_gate && ls_gate && output_good_flag_oe)
    else $error("over-voltage latch missing");
  ov_latch_a:
    assert property (ovl_r |-> !hs_gate) else $error("high side left the latch");
  ov_release_a:
    assert property ((ovl_r && output_sense_input < ov_lo) [*4] |-> ##[0:3] !ls_gate)
    else $error("low side kept on below release");
  thermal_off_a:
    assert property ((die_temp > ot_lim) [*4] |-> ##[0:3]
      (!hs_gate && !ls_gate && ss_ref_mv == 12'h000)) else $error("thermal stop missing");
  good_low_a:
    assert property ((output_sense_input < pg_lo) [*3] |-> ##[0:3] output_good_flag_oe)
    else $error("good kept below lower level");
  good_enable_a:
    assert property (!en_ok [*4] |-> output_good_flag_oe) else $error("good while disabled");
  min_on_a:
    assert property ($rose(hs_gate) && &small_r |->
      (hs_gate || !ls_gate) [*5] ##1 (!hs_gate || !small_r[0]))
    else $error("start-up pulse not minimal");
  ls_after_hs_a:
    assert property ($fell(hs_gate) && !output_good_flag_oe |-> ls_gate [*8])
    else $error("low side off in off-time");
  good_pulse_a:
    assert property (!output_good_flag_oe |-> seen_r)
    else $error("good before first high-side pulse");
  oc_seen_c: cover property (ls_gate && ss_ref_mv == 12'h000 && ls_current > 8'h3C);
  ov_seen_c: cover property ($rose(ovl_r));
  good_seen_c: cover property ($fell(output_good_flag_oe));
endmodule // fault_checker
bind regulator_fault_power_good fault_checker i_chk (
  .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .en_ok(en_ok),
  .bias_ok(bias_ok), .init_done(init_done), .output_sense_input(output_sense_input),
  .ls_current(ls_current), .die_temp(die_temp), .ctl_on_cycles(ctl_on_cycles),
  .hs_gate(hs_gate), .ls_gate(ls_gate), .ss_ref_mv(ss_ref_mv),
  .output_good_flag_o(output_good_flag_o), .output_good_flag_oe(output_good_flag_oe)
);
`default_nettype wire

/* power_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
  // from the regulator
  input wire logic ls_gate,
  // bench settings
  input wire logic [7:0] sense_set,
  input wire logic [7:0] load_set,
  input wire logic [7:0] temp_set,
  // sensing back to the regulator
  output logic [7:0] output_sense_input,
  output logic [7:0] ls_current,
  output logic [7:0] die_temp,
  output logic [7:0] ctl_on_cycles
);
  assign output_sense_input = sense_set;
  // the sensed current is zero whenever the low-side switch is not conducting
  assign ls_current = ls_gate ? load_set : 8'h00;
  assign die_temp = temp_set;
  assign ctl_on_cycles = 8'h14;
endmodule // power_stage_model
`default_nettype wire

/* regulator_fault_power_good_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module regulator_fault_power_good_bench;
  logic ref_clk, nrst, reg_wr, reg_rd, en_ok, hs_gate, ls_gate, pg_o, pg_oe;
  logic bias_ok, init_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, sense, cur, temp, on_cyc;
  logic [7:0] sense_set, load_set, temp_set, d;
  logic [11:0] ss, s0;
  int miscompares, n_checks;
  regulator_fault_power_good i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .en_ok(en_ok),
    .bias_ok(bias_ok), .init_done(init_done), .output_sense_input(sense), .ls_current(cur),
    .die_temp(temp), .ctl_on_cycles(on_cyc), .hs_gate(hs_gate), .ls_gate(ls_gate),
    .ss_ref_mv(ss), .output_good_flag_o(pg_o), .output_good_flag_oe(pg_oe)
  );
  power_stage_model i_stage (
    .ls_gate(ls_gate), .sense_set(sense_set), .load_set(load_set), .temp_set(temp_set),
    .output_sense_input(sense), .ls_current(cur), .die_temp(temp), .ctl_on_cycles(on_cyc)
  );
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask
  // polls the state field of the status register
  task automatic wait_st(input logic [2:0] s, input int n);
    rd(8'h1E, d);
    for (int i = 0; i < n && d[2:0] !== s; i++) rd(8'h1E, d);
    cmp({9'h000, d[2:0]}, {9'h000, s});
  endtask
  task automatic t_regs;
    logic [7:0] a [4] = '{8'h14, 8'h17, 8'h18, 8'h19};
    logic [7:0] r0 [4] = '{8'h01, 8'h03, 8'h02, 8'h03};
    logic [7:0] rf [4] = '{8'h0D, 8'h03, 8'h03, 8'h03};
    for (int i = 0; i < 4; i++) begin
      rd(a[i], d);
      cmp({4'h0, d}, {4'h0, r0[i]});
      wr(a[i], 8'hFF);
      rd(a[i], d);
      cmp({4'h0, d}, {4'h0, rf[i]});
      wr(a[i], r0[i]);
    end
    wr(8'h30, 8'h5A);
    rd(8'h30, d);
    cmp({4'h0, d}, 12'h000);
    wr(8'h1E, 8'hFF);
    wait_st(3'h0, 1);
    $display("test regs done");
  endtask
  task automatic t_good;
    logic [7:0] up;
    time t0;
    tick(1);
    en_ok <= 1'b1;
    wait_st(3'h2, 200);
    @(posedge hs_gate);
    t0 = $time;
    @(posedge hs_gate);
    cmp(12'(($time - t0) / 10), 12'(fault_pkg::PERIOD_3V3_CYC));
    for (int c = 0; c < 4; c++) begin
      up = 8'h50 + 8'(c * 5);
      wr(8'h18, 8'(c));
      tick(1);
      sense_set <= up + 8'h01;
      tick(20);
      cmp({10'h000, pg_o, pg_oe}, 12'h000);
      sense_set <= up - 8'h04;
      tick(20);
      cmp({11'h000, pg_oe}, 12'h000);
      sense_set <= up - 8'h06;
      tick(20);
      cmp({11'h000, pg_oe}, 12'h001);
    end
    wr(8'h18, 8'h02);
    $display("test good done");
  endtask
  task automatic t_oc;
    time t0;
    tick(1);
    sense_set <= 8'h5F;
    tick(20);
    load_set <= 8'h46;
    for (int n = 0; n < 200 && ss !== 12'h000; n++) tick(1);
    tick(2);
    cmp({9'h000, hs_gate, ls_gate, pg_oe}, 12'h003);
    tick(20);
    wait_st(3'h3, 1);
    tick(1);
    load_set <= 8'h00;
    sense_set <= 8'h00;
    wait_st(3'h4, 10);
    cmp({10'h000, hs_gate, ls_gate}, 12'h000);
    tick(1);
    load_set <= 8'h46;
    wait_st(3'h3, 1200);
    tick(1);
    load_set <= 8'h00;
    wait_st(3'h4, 10);
    t0 = $time;
    wait_st(3'h1, 1100);
    cmp({11'h000, ($time - t0) / 10 inside {[1990:2010]}}, 12'h001);
    wait_st(3'h2, 200);
    $display("test oc done");
  endtask
  task automatic t_ov;
    wr(8'h17, 8'h00);
    tick(1);
    sense_set <= 8'h6E;
    tick(300);
    sense_set <= 8'h00;
    wait_st(3'h2, 1);
    tick(1);
    sense_set <= 8'h6E;
    tick(600);
    wait_st(3'h5, 1);
    cmp({9'h000, hs_gate, ls_gate, pg_oe}, 12'h003);
    tick(1);
    sense_set <= 8'h65;
    tick(20);
    cmp({11'h000, ls_gate}, 12'h001);
    sense_set <= 8'h63;
    tick(20);
    cmp({10'h000, hs_gate, ls_gate}, 12'h000);
    wait_st(3'h5, 1);
    tick(1);
    en_ok <= 1'b0;
    sense_set <= 8'h00;
    wr(8'h17, 8'h03);
    wait_st(3'h0, 5);
    tick(1);
    en_ok <= 1'b1;
    wait_st(3'h2, 200);
    $display("test ov done");
  endtask
  task automatic t_ot;
    wr(8'h19, 8'h00);
    tick(1);
    temp_set <= 8'h50;
    tick(10);
    wait_st(3'h6, 1);
    cmp(ss, 12'h000);
    cmp({10'h000, hs_gate, ls_gate}, 12'h000);
    tick(1);
    temp_set <= 8'h38;
    tick(10);
    wait_st(3'h6, 1);
    tick(1);
    temp_set <= 8'h37;
    wait_st(3'h2, 200);
    wr(8'h19, 8'h03);
    $display("test ot done");
  endtask
  task automatic t_rate;
    // each pass drops a different one of enable, bias and init
    for (int f = 0; f < 3; f++) begin
      tick(1);
      {en_ok, bias_ok, init_done} <= ~(3'h4 >> f);
      wr(8'h14, (f != 0) ? 8'h08 : 8'h01);
      wait_st(3'h0, 5);
      tick(1);
      {en_ok, bias_ok, init_done} <= 3'h7;
      wait (ss !== 12'h000);
      tick(1);
      s0 = ss;
      tick(500);
      cmp(ss - s0, (f != 0) ? 12'h00A : 12'h005);
    end
    sense_set <= 8'h5F;
    tick(30);
    cmp({11'h000, pg_oe}, 12'h001);
    $display("test rate done");
  endtask
  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    {nrst, reg_wr, reg_rd, en_ok} = 4'h0;
    {bias_ok, init_done} = 2'h3;
    {reg_addr, reg_wdata, sense_set, load_set} = 32'h0000_0000;
    temp_set = 8'h19;
    miscompares = 0;
    n_checks = 0;
    tick(10);
    nrst <= 1'b1;
    tick(2);
    t_regs;
    t_good;
    t_oc;
    t_ov;
    t_ot;
    t_rate;
    finish_test;
  end
  initial begin
    #300_000;
    miscompares++;
    finish_test;
  end
endmodule // regulator_fault_power_good_bench
`default_nettype wire
